// ===== msfc_regs.svh
// Purpose: offsets, field positions, reset values and levels of the modem status block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word
// Notes:   definitions only
`ifndef MSFC_REGS_SVH
`define MSFC_REGS_SVH

// register byte offsets
`define MSFC_OFS_MODEM_LINE_STATUS  8'h00
`define MSFC_OFS_SCRATCH_BYTE       8'h04
`define MSFC_OFS_FEATURE_CONTROL    8'h08
`define MSFC_OFS_RESUME_FIRST       8'h0c
`define MSFC_OFS_RESUME_SECOND      8'h10
`define MSFC_OFS_PAUSE_FIRST        8'h14
`define MSFC_OFS_PAUSE_SECOND       8'h18
`define MSFC_OFS_LINE_CTRL          8'h1c
`define MSFC_OFS_INT_STATUS         8'h20
`define MSFC_OFS_INT_ENABLE         8'h24
`define MSFC_OFS_INT_CLEAR          8'h28

// line control fields
`define MSFC_LC_RTS_BIT             0
`define MSFC_LC_TRIG_LSB            1

// interrupt status bits
`define MSFC_INT_MODEM              0
`define MSFC_INT_RX_TRIGGER         1
`define MSFC_INT_RESUME_SEEN        2
`define MSFC_INT_PAUSE_SEEN         3
`define MSFC_INT_WIDTH              4

// reset values
`define MSFC_RST_BYTE               8'h00
`define MSFC_RST_INT                4'h0

// receive fifo depth and trigger levels
`define MSFC_FIFO_DEPTH             6'h20
`define MSFC_TRIG_LVL0              6'h08
`define MSFC_TRIG_LVL1              6'h10
`define MSFC_TRIG_LVL2              6'h18
`define MSFC_TRIG_LVL3              6'h1c

// axi responses
`define MSFC_RESP_OKAY              2'h0
`define MSFC_RESP_SLVERR            2'h2

`endif

// ===== msfc_pkg.sv
// Purpose: types shared by the modem status and flow control block
// Assumes: nothing beyond the register header
// Notes:   types only
package msfc_pkg;

    // feature_control layout, msb first
    typedef struct packed {
        logic       auto_cts_enable;
        logic       auto_rts_enable;
        logic       special_detect;
        logic       enhanced_enable;
        logic [1:0] tx_select;
        logic [1:0] rx_compare;
    } msfc_feature_t;

    // modem control inputs, pin polarity (active low)
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } msfc_modem_t;

    typedef enum logic [1:0] {
        MSFC_SEL_NONE   = 2'b00,
        MSFC_SEL_SECOND = 2'b01,
        MSFC_SEL_FIRST  = 2'b10,
        MSFC_SEL_BOTH   = 2'b11
    } msfc_sel_t;

endpackage

// ===== msfc_top.sv
// Purpose: modem status change tracking, scratch byte and flow-control features
// Assumes: modem inputs asynchronous, all other inputs synchronous to sys_clk
// Notes:   registers reached over AXI4-Lite
// How it works
// - DCD pin toggle sets the DCD change flag and requests a modem interrupt.
// - RI pin leaving logic 0 sets the ring change flag, bit 2.
// - DSR pin toggle sets change flag bit 1 and requests a modem interrupt.
// - CTS pin toggle sets change flag bit 0 and requests a modem interrupt.
// - modem interrupt is high while any change flag in bits 0..3 is set.
// - eight-bit scratch byte stores writes, returns them, affects nothing else.
// - auto CTS on: transmit halts while CTS pin is 1, resumes at 0.
// - auto CTS and auto RTS enables reset to 0, disabled.
// - auto RTS: interrupt at trigger level, RTS pin 1 at next level.
// - auto RTS: RTS pin back to 0 once fifo drops below level minus one.
// - auto RTS: line control readback returns the written RTS bit; RTS is manual when disabled.
// - feature bits 0..3 select single or dual software flow control.
// - dual mode treats two resume or two pause characters as one sequence.
// - reading modem status clears the four change flags.
// - auto CTS lets a character in progress finish before stopping.
// - bits 3:2 pick transmit characters, bits 1:0 receive comparison.
`timescale 1ns/1ns
`include "msfc_regs.svh"

module msfc_top
    import msfc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // modem lines
    input  msfc_modem_t      modem_in,
    output logic             rts_n,
    // transmitter and receiver side
    input  wire logic        tx_busy,
    output logic             tx_allow,
    output logic [1:0]       tx_char_select,
    input  wire logic [5:0]  rx_fifo_level,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_char_valid,
    output logic             resume_seen,
    output logic             pause_seen,
    // interrupts
    output logic             modem_irq,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // modem input synchronisers
    msfc_modem_t sync1_q;
    msfc_modem_t sync2_q;
    msfc_modem_t prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                    prev_q[gi]  <= 1'b1;
                end else begin
                    sync1_q[gi] <= modem_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // trigger level lookup, used for the level and for the next one up
    function automatic logic [5:0] trig_level(input logic [2:0] idx);
        case (idx)
            3'd0:    trig_level = `MSFC_TRIG_LVL0;
            3'd1:    trig_level = `MSFC_TRIG_LVL1;
            3'd2:    trig_level = `MSFC_TRIG_LVL2;
            3'd3:    trig_level = `MSFC_TRIG_LVL3;
            default: trig_level = `MSFC_FIFO_DEPTH;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [3:0]          delta_q, delta_d;
    logic [7:0]          scratch_q, scratch_d;
    msfc_feature_t       feat_q, feat_d;
    logic [7:0]          res1_q, res1_d, res2_q, res2_d;
    logic [7:0]          pau1_q, pau1_d, pau2_q, pau2_d;
    logic [2:0]          lctrl_q, lctrl_d;
    logic [3:0]          ista_q, ista_d, ien_q, ien_d;
    logic                rts_n_q, rts_n_d, allow_q, allow_d;
    logic                modem_irq_q, modem_irq_d, irq_q, irq_d;
    logic                hit_res_q, hit_res_d, hit_pau_q, hit_pau_d;
    logic                half_res_q, half_res_d, half_pau_q, half_pau_d;
    logic                above_q, above_d;
    // bus state
    logic                awrdy_q, awrdy_d, wrdy_q, wrdy_d, bval_q, bval_d;
    logic [7:0]          waddr_q, waddr_d;
    logic [31:0]         wdata_q, wdata_d;
    logic [3:0]          wstrb_q, wstrb_d;
    logic                bslv_q, bslv_d;
    logic                arrdy_q, arrdy_d, rval_q, rval_d, rslv_q, rslv_d;
    logic [31:0]         rdata_q, rdata_d;

    logic [3:0]          chg;
    logic                wr_fire, rd_fire, msr_read;
    logic [5:0]          lvl, lvl_next;
    logic [3:0]          ev;
    logic                cmp_first, cmp_second, cmp_both;

    always_comb begin
        // change detection on synchronised levels
        chg[3] = sync2_q.dcd_n ^ prev_q.dcd_n;
        chg[2] = sync2_q.ri_n & ~prev_q.ri_n;
        chg[1] = sync2_q.dsr_n ^ prev_q.dsr_n;
        chg[0] = sync2_q.cts_n ^ prev_q.cts_n;

        wr_fire  = ~awrdy_q & ~wrdy_q & ~bval_q;
        rd_fire  = s_axi_arvalid & arrdy_q;
        msr_read = rd_fire & (s_axi_araddr == `MSFC_OFS_MODEM_LINE_STATUS);
        lvl      = trig_level({1'b0, lctrl_q[2:1]});
        lvl_next = trig_level({1'b0, lctrl_q[2:1]} + 3'd1);

        // defaults hold state
        delta_d   = delta_q;
        scratch_d = scratch_q;
        feat_d    = feat_q;
        res1_d    = res1_q;
        res2_d    = res2_q;
        pau1_d    = pau1_q;
        pau2_d    = pau2_q;
        lctrl_d   = lctrl_q;
        ien_d     = ien_q;
        ista_d    = ista_q;

        // read clears flags, a change in the same cycle still lands
        if (msr_read)
            delta_d = 4'h0;
        delta_d = delta_d | chg;

        // register writes once address and data are both held
        if (wr_fire && wstrb_q[0]) begin
            case (waddr_q)
                `MSFC_OFS_SCRATCH_BYTE:    scratch_d = wdata_q[7:0];
                `MSFC_OFS_FEATURE_CONTROL: feat_d    = wdata_q[7:0];
                `MSFC_OFS_RESUME_FIRST:    res1_d    = wdata_q[7:0];
                `MSFC_OFS_RESUME_SECOND:   res2_d    = wdata_q[7:0];
                `MSFC_OFS_PAUSE_FIRST:     pau1_d    = wdata_q[7:0];
                `MSFC_OFS_PAUSE_SECOND:    pau2_d    = wdata_q[7:0];
                `MSFC_OFS_LINE_CTRL:       lctrl_d   = wdata_q[2:0];
                `MSFC_OFS_INT_ENABLE:      ien_d     = wdata_q[3:0];
                `MSFC_OFS_INT_CLEAR:       ista_d    = ista_q & ~wdata_q[3:0];
                default: begin
                end
            endcase
        end

        // receive comparison decode
        cmp_first  = (feat_q.rx_compare == MSFC_SEL_FIRST);
        cmp_second = (feat_q.rx_compare == MSFC_SEL_SECOND);
        cmp_both   = (feat_q.rx_compare == MSFC_SEL_BOTH);
        hit_res_d  = 1'b0;
        hit_pau_d  = 1'b0;
        half_res_d = half_res_q;
        half_pau_d = half_pau_q;
        if (rx_char_valid) begin
            if (cmp_both) begin
                // dual mode: first char arms, second completes the pair
                hit_res_d  = half_res_q & (rx_char == res2_q);
                hit_pau_d  = half_pau_q & (rx_char == pau2_q);
                half_res_d = (rx_char == res1_q);
                half_pau_d = (rx_char == pau1_q);
            end else begin
                hit_res_d  = (cmp_first & (rx_char == res1_q)) |
                             (cmp_second & (rx_char == res2_q));
                hit_pau_d  = (cmp_first & (rx_char == pau1_q)) |
                             (cmp_second & (rx_char == pau2_q));
                half_res_d = 1'b0;
                half_pau_d = 1'b0;
            end
        end

        // sticky events; set wins over the write-one clear
        above_d = (rx_fifo_level >= lvl);
        ev[`MSFC_INT_MODEM]       = |chg;
        ev[`MSFC_INT_RX_TRIGGER]  = feat_q.auto_rts_enable & above_d & ~above_q;
        ev[`MSFC_INT_RESUME_SEEN] = hit_res_q;
        ev[`MSFC_INT_PAUSE_SEEN]  = hit_pau_q;
        ista_d = ista_d | ev;

        // auto cts gate, a character under way always completes
        if (!feat_q.auto_cts_enable || !sync2_q.cts_n)
            allow_d = 1'b1;
        else if (!tx_busy)
            allow_d = 1'b0;
        else
            allow_d = allow_q;

        // auto rts hysteresis around the programmed level
        if (!feat_q.auto_rts_enable)
            rts_n_d = ~lctrl_q[`MSFC_LC_RTS_BIT];
        else if (rx_fifo_level >= lvl_next)
            rts_n_d = 1'b1;
        else if (rx_fifo_level < lvl - 6'd1)
            rts_n_d = 1'b0;
        else
            rts_n_d = rts_n_q;

        modem_irq_d = |delta_d;
        irq_d       = |(ista_d & ien_d);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            delta_q     <= 4'h0;
            scratch_q   <= `MSFC_RST_BYTE;
            feat_q      <= `MSFC_RST_BYTE;
            res1_q      <= `MSFC_RST_BYTE;
            res2_q      <= `MSFC_RST_BYTE;
            pau1_q      <= `MSFC_RST_BYTE;
            pau2_q      <= `MSFC_RST_BYTE;
            lctrl_q     <= 3'h0;
            ista_q      <= `MSFC_RST_INT;
            ien_q       <= `MSFC_RST_INT;
            allow_q     <= 1'b1;
            rts_n_q     <= 1'b1;
            modem_irq_q <= 1'b0;
            irq_q       <= 1'b0;
            hit_res_q   <= 1'b0;
            hit_pau_q   <= 1'b0;
            half_res_q  <= 1'b0;
            half_pau_q  <= 1'b0;
            above_q     <= 1'b0;
        end else begin
            delta_q     <= delta_d;
            scratch_q   <= scratch_d;
            feat_q      <= feat_d;
            res1_q      <= res1_d;
            res2_q      <= res2_d;
            pau1_q      <= pau1_d;
            pau2_q      <= pau2_d;
            lctrl_q     <= lctrl_d;
            ista_q      <= ista_d;
            ien_q       <= ien_d;
            allow_q     <= allow_d;
            rts_n_q     <= rts_n_d;
            modem_irq_q <= modem_irq_d;
            irq_q       <= irq_d;
            hit_res_q   <= hit_res_d;
            hit_pau_q   <= hit_pau_d;
            half_res_q  <= half_res_d;
            half_pau_q  <= half_pau_d;
            above_q     <= above_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data latched independently, one write at a time
    always_comb begin
        awrdy_d = awrdy_q;
        wrdy_d  = wrdy_q;
        bval_d  = bval_q;
        bslv_d  = bslv_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        if (awrdy_q && s_axi_awvalid) begin
            awrdy_d = 1'b0;
            waddr_d = s_axi_awaddr;
        end
        if (wrdy_q && s_axi_wvalid) begin
            wrdy_d  = 1'b0;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            bval_d = 1'b1;
            bslv_d = (waddr_q > `MSFC_OFS_INT_CLEAR) || (waddr_q[1:0] != 2'b00) ||
                     (waddr_q == `MSFC_OFS_MODEM_LINE_STATUS) ||
                     (waddr_q == `MSFC_OFS_INT_STATUS);
        end
        if (bval_q && s_axi_bready) begin
            bval_d  = 1'b0;
            awrdy_d = 1'b1;
            wrdy_d  = 1'b1;
        end

        arrdy_d = arrdy_q;
        rval_d  = rval_q;
        rslv_d  = rslv_q;
        rdata_d = rdata_q;
        if (rd_fire) begin
            arrdy_d = 1'b0;
            rval_d  = 1'b1;
            rslv_d  = 1'b0;
            rdata_d = 32'h0;
            case (s_axi_araddr)
                `MSFC_OFS_MODEM_LINE_STATUS:
                    rdata_d[7:0] = {~sync2_q, delta_q};
                `MSFC_OFS_SCRATCH_BYTE:    rdata_d[7:0] = scratch_q;
                `MSFC_OFS_FEATURE_CONTROL: rdata_d[7:0] = feat_q;
                `MSFC_OFS_RESUME_FIRST:    rdata_d[7:0] = res1_q;
                `MSFC_OFS_RESUME_SECOND:   rdata_d[7:0] = res2_q;
                `MSFC_OFS_PAUSE_FIRST:     rdata_d[7:0] = pau1_q;
                `MSFC_OFS_PAUSE_SECOND:    rdata_d[7:0] = pau2_q;
                `MSFC_OFS_LINE_CTRL:       rdata_d[2:0] = lctrl_q;
                `MSFC_OFS_INT_STATUS:      rdata_d[3:0] = ista_q;
                `MSFC_OFS_INT_ENABLE:      rdata_d[3:0] = ien_q;
                `MSFC_OFS_INT_CLEAR:       rdata_d      = 32'h0;
                default:                   rslv_d       = 1'b1;
            endcase
        end
        if (rval_q && s_axi_rready) begin
            rval_d  = 1'b0;
            arrdy_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awrdy_q <= 1'b1;
            wrdy_q  <= 1'b1;
            bval_q  <= 1'b0;
            bslv_q  <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            arrdy_q <= 1'b1;
            rval_q  <= 1'b0;
            rslv_q  <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            awrdy_q <= awrdy_d;
            wrdy_q  <= wrdy_d;
            bval_q  <= bval_d;
            bslv_q  <= bslv_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            arrdy_q <= arrdy_d;
            rval_q  <= rval_d;
            rslv_q  <= rslv_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready  = awrdy_q;
    assign s_axi_wready   = wrdy_q;
    assign s_axi_bvalid   = bval_q;
    assign s_axi_bresp    = bslv_q ? `MSFC_RESP_SLVERR : `MSFC_RESP_OKAY;
    assign s_axi_arready  = arrdy_q;
    assign s_axi_rvalid   = rval_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rslv_q ? `MSFC_RESP_SLVERR : `MSFC_RESP_OKAY;
    assign rts_n          = rts_n_q;
    assign tx_allow       = allow_q;
    assign tx_char_select = feat_q.tx_select;
    assign resume_seen    = hit_res_q;
    assign pause_seen     = hit_pau_q;
    assign modem_irq      = modem_irq_q;
    assign irq            = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_dcd_flag;
        @(posedge sys_clk) disable iff (rst)
        (sync2_q.dcd_n != prev_q.dcd_n) |=> delta_q[3];
    endproperty
    a_dcd_flag: assert property (p_dcd_flag) else $error("dcd change not flagged");

    property p_ri_flag;
        @(posedge sys_clk) disable iff (rst)
        $rose(sync2_q.ri_n) |-> ##1 delta_q[2];
    endproperty
    a_ri_flag: assert property (p_ri_flag) else $error("ri release not flagged");

    property p_dsr_flag;
        @(posedge sys_clk) disable iff (rst)
        $changed(sync2_q.dsr_n) |=> delta_q[1] && modem_irq;
    endproperty
    a_dsr_flag: assert property (p_dsr_flag) else $error("dsr change lost");

    property p_cts_flag;
        @(posedge sys_clk) disable iff (rst)
        $changed(sync2_q.cts_n) |=> delta_q[0];
    endproperty
    a_cts_flag: assert property (p_cts_flag) else $error("cts change lost");

    property p_modem_irq;
        @(posedge sys_clk) disable iff (rst)
        modem_irq == (|delta_q);
    endproperty
    a_modem_irq: assert property (p_modem_irq) else $error("modem irq wrong");

    property p_read_clears;
        @(posedge sys_clk) disable iff (rst)
        (msr_read && chg == 4'h0) |=> (delta_q == 4'h0) && rval_q;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("flags not cleared");

    property p_cts_halt;
        @(posedge sys_clk) disable iff (rst)
        (feat_q.auto_cts_enable && sync2_q.cts_n && !tx_busy) |=> !tx_allow;
    endproperty
    a_cts_halt: assert property (p_cts_halt) else $error("auto cts did not halt");

    property p_cts_finish;
        @(posedge sys_clk) disable iff (rst)
        (tx_allow && tx_busy) |=> tx_allow;
    endproperty
    a_cts_finish: assert property (p_cts_finish) else $error("character cut short");

    property p_rts_high;
        @(posedge sys_clk) disable iff (rst)
        (feat_q.auto_rts_enable && rx_fifo_level >= lvl_next) |=> rts_n;
    endproperty
    a_rts_high: assert property (p_rts_high) else $error("rts not raised");

    property p_rts_low;
        @(posedge sys_clk) disable iff (rst)
        (feat_q.auto_rts_enable && rx_fifo_level < lvl - 6'd1) |=> !rts_n;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("rts not released");

endmodule

// ===== msfc_modem_model.sv
// Purpose: modem or peer device on the control lines of msfc_top
// Assumes: the bench commands the line levels and the fifo fill level
// Notes:   pins move off the clock edge, as an unsynchronised peer would
`timescale 1ns/1ns

module msfc_modem_model
    import msfc_pkg::*;
(
    // clock
    input  wire logic       sys_clk,
    // commands from the bench
    input  msfc_modem_t     pins_set,
    input  wire logic       busy_set,
    input  wire logic [5:0] level_set,
    // lines toward the block
    output msfc_modem_t     modem_in,
    output logic            tx_busy,
    output logic [5:0]      rx_fifo_level
);
    initial begin
        modem_in = 4'hf;
        tx_busy = 1'b0;
        rx_fifo_level = 6'h00;
    end
    // async pin edges land 7 ns after the rising clock edge to exercise the synchroniser
    always @(posedge sys_clk) begin
        modem_in <= #7 pins_set;
        tx_busy <= busy_set;
        rx_fifo_level <= level_set;
    end
endmodule

// ===== msfc_top_tb_top.sv
// Purpose: register level bench for msfc_top
// Assumes: msfc_modem_model stands on the modem lines
// Notes:   fixed waits cover the sync and register latency of the block
`timescale 1ns/1ns

module msfc_top_tb_top
    import msfc_pkg::*;
;
    logic        sys_clk, rst, aw_v, w_v, b_r, ar_v, r_r, rx_v, busy, busy_q;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, rts_n, tx_allow, res_s, pau_s, m_irq, irq;
    logic [1:0]  bresp, rresp, tx_sel;
    logic [5:0]  lvl, rx_lvl;
    logic [7:0]  aw_a, ar_a, rx_c;
    logic [31:0] w_d, rdata;
    msfc_modem_t pins, modem_in;
    int          fails, n_checks, n_res, n_pau;
    // level times two plus expected rts_n
    int          rts_tab[5] = '{30, 33, 17, 15, 12};

    msfc_top DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .modem_in(modem_in), .rts_n(rts_n), .tx_busy(busy_q), .tx_allow(tx_allow),
        .tx_char_select(tx_sel), .rx_fifo_level(rx_lvl), .rx_char(rx_c),
        .rx_char_valid(rx_v), .resume_seen(res_s), .pause_seen(pau_s),
        .modem_irq(m_irq), .irq(irq));
    msfc_modem_model PEER (.sys_clk(sys_clk), .pins_set(pins), .busy_set(busy),
        .level_set(lvl), .modem_in(modem_in), .tx_busy(busy_q), .rx_fifo_level(rx_lvl));

    always @(posedge sys_clk) begin
        if (res_s === 1'b1) n_res <= n_res + 1;
        if (pau_s === 1'b1) n_pau <= n_pau + 1;
    end
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (aw_v && aw_rdy) aw_v <= 1'b0;
            if (w_v && w_rdy) w_v <= 1'b0;
        end while (b_v !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            complete_run();
        end
        chk("bresp", e, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (ar_v && ar_rdy) ar_v <= 1'b0;
        end while (r_v !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            complete_run();
        end
        chk("rresp", er, rresp);
        chk("rdata", e, rdata);
    endtask
////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {aw_v, w_v, b_r, ar_v, r_r, rx_v, busy} = 7'h00;
        {aw_a, ar_a, rx_c, lvl, w_d} = 62'h0;
        pins = 4'hf;
        {fails, n_checks, n_res, n_pau} = 128'h0;
        tick(3);
        rst <= 1'b0;
        tick(1);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        chk("rts_n", 32'h1, rts_n);
        wr(8'h04, 32'hffffffa5, 2'h0);
        rd(8'h04, 32'ha5, 2'h0);
        wr(8'h00, 32'h1, 2'h2);
        rd(8'h3c, 32'h0, 2'h2);
        $display("test reset_regs done");
        wr(8'h24, 32'h1, 2'h0);
        for (int i = 0; i < 4; i++) begin
            pins[i] <= 1'b0;
            tick(6);
            chk("modem_irq", 32'(i != 2), m_irq);
            rd(8'h00, (32'h10 << i) | (32'(i != 2) << i), 2'h0);
            rd(8'h00, 32'h10 << i, 2'h0);
            pins[i] <= 1'b1;
            tick(6);
            chk("irq", 32'h1, irq);
            rd(8'h00, 32'h1 << i, 2'h0);
            wr(8'h28, 32'hf, 2'h0);
            rd(8'h20, 32'h0, 2'h0);
        end
        wr(8'h24, 32'h0, 2'h0);
        pins[3] <= 1'b0;
        tick(6);
        chk("irq", 32'h0, irq);
        rd(8'h20, 32'h1, 2'h0);
        rd(8'h00, 32'h88, 2'h0);
        $display("test modem_status done");
        busy <= 1'b1;
        wr(8'h08, 32'h80, 2'h0);
        rd(8'h08, 32'h80, 2'h0);
        tick(4);
        chk("tx_allow", 32'h1, tx_allow);
        busy <= 1'b0;
        tick(4);
        chk("tx_allow", 32'h0, tx_allow);
        pins <= 4'h6;
        tick(6);
        chk("tx_allow", 32'h1, tx_allow);
        rd(8'h00, 32'h91, 2'h0);
        $display("test auto_cts done");
        wr(8'h1c, 32'h0, 2'h0);
        wr(8'h08, 32'h40, 2'h0);
        wr(8'h28, 32'hf, 2'h0);
        foreach (rts_tab[k]) begin
            lvl <= 6'(rts_tab[k] / 2);
            tick(4);
            chk("rts_n", 32'(rts_tab[k] % 2), rts_n);
        end
        rd(8'h20, 32'h2, 2'h0);
        wr(8'h08, 32'h0, 2'h0);
        wr(8'h1c, 32'h1, 2'h0);
        tick(2);
        chk("rts_n", 32'h0, rts_n);
        $display("test auto_rts done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h08, 32'(m * 4 + 3), 2'h0);
            tick(2);
            chk("tx_sel", 32'(m), tx_sel);
        end
        wr(8'h0c, 32'h11, 2'h0);
        wr(8'h10, 32'h12, 2'h0);
        foreach (rts_tab[k]) begin
            rx_c <= (k % 2) ? 8'h11 : 8'h12;
            rx_v <= (k < 3);
            tick(1);
        end
        tick(4);
        chk("resume_count", 32'h1, n_res);
        wr(8'h14, 32'h33, 2'h0);
        for (int m = 1; m < 3; m++) begin
            wr(8'h08, 32'(m), 2'h0);
            rx_c <= (m == 2) ? 8'h33 : 8'h12;
            rx_v <= 1'b1;
            tick(1);
            rx_v <= 1'b0;
            tick(4);
        end
        chk("resume_count", 32'h2, n_res);
        chk("pause_count", 32'h1, n_pau);
        rd(8'h20, 32'he, 2'h0);
        $display("test soft_flow done");
        complete_run();
    end
endmodule
